// File: include/wwd_pkg.sv
package wwd_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 24;
    localparam int ST_W = 4;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TIMEOUT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_WARN = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_WINDOW = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_FEED = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h20;

    localparam int CTRL_EN = 0;
    localparam int CTRL_FAULT_IRQ = 1;
    localparam int CTRL_WIN_EN = 2;

    localparam int ST_WARN = 0;
    localparam int ST_FEED_FAULT = 1;
    localparam int ST_WIN_FAULT = 2;
    localparam int ST_WD_RESET = 3;

    localparam logic [7:0] FEED_KEY1 = 8'haa;
    localparam logic [7:0] FEED_KEY2 = 8'h55;

    localparam logic [CNT_W-1:0] TIMEOUT_MIN = 24'h000100;
    localparam logic [CNT_W-1:0] TIMEOUT_RST = 24'hffffff;
    localparam logic [CNT_W-1:0] WARN_RST = 24'h000000;
    localparam logic [CNT_W-1:0] WINDOW_RST = 24'hffffff;
    localparam logic [1:0] PRESC_LAST = 2'h3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } wwd_req_s;

    typedef struct packed {
        logic en;
        logic fault_irq;
        logic win_en;
        logic [CNT_W-1:0] timeout;
        logic [CNT_W-1:0] warn;
        logic [CNT_W-1:0] window;
        logic [CNT_W-1:0] count;
        logic [1:0] presc;
        logic feed_armed;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] irq_en;
        logic [DATA_W-1:0] rdata;
        logic chip_rst;
        logic [2:0] rc_sync;
    } wwd_state_s;
endpackage

// File: core/wwd_windowed_watchdog.sv
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module wwd_windowed_watchdog (
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_por_rst,
    input wire logic i_internal_rc_oscillator,
    input wire wwd_pkg::wwd_req_s i_req,
    output logic [wwd_pkg::DATA_W-1:0] o_rdata,
    output logic o_irq,
    output logic o_chip_rst
);
    localparam wwd_pkg::wwd_state_s ST_RST = '{
        en: 1'b0,
        fault_irq: 1'b0,
        win_en: 1'b0,
        timeout: wwd_pkg::TIMEOUT_RST,
        warn: wwd_pkg::WARN_RST,
        window: wwd_pkg::WINDOW_RST,
        count: wwd_pkg::TIMEOUT_RST,
        presc: 2'h0,
        feed_armed: 1'b0,
        status: 4'h0,
        irq_en: 4'h0,
        rdata: 32'h0,
        chip_rst: 1'b0,
        rc_sync: 3'h0
    };

    wwd_pkg::wwd_state_s st;
    wwd_pkg::wwd_state_s next_st;

    logic rc_rise;
    logic step;
    logic feed_ok;
    logic ev_warn;
    logic ev_feed_fault;
    logic ev_win_fault;
    logic ev_timeout;
    logic fault;
    logic [wwd_pkg::ST_W-1:0] st_set;
    logic [wwd_pkg::ST_W-1:0] st_clr;

    function automatic logic [wwd_pkg::DATA_W-1:0] ext24(input logic [wwd_pkg::CNT_W-1:0] v);
        ext24 = {8'h00, v};
    endfunction

    function automatic logic [wwd_pkg::CNT_W-1:0] clamp_timeout(
        input logic [wwd_pkg::CNT_W-1:0] v);
        clamp_timeout = (v < wwd_pkg::TIMEOUT_MIN) ? wwd_pkg::TIMEOUT_MIN : v;
    endfunction

    function automatic logic [wwd_pkg::DATA_W-1:0] read_mux(
        input wwd_pkg::wwd_state_s s,
        input logic [wwd_pkg::ADDR_W-1:0] a);
        case (a)
            wwd_pkg::OFF_CTRL: read_mux = {29'h0, s.win_en, s.fault_irq, s.en};
            wwd_pkg::OFF_TIMEOUT: read_mux = ext24(s.timeout);
            wwd_pkg::OFF_WARN: read_mux = ext24(s.warn);
            wwd_pkg::OFF_WINDOW: read_mux = ext24(s.window);
            wwd_pkg::OFF_COUNT: read_mux = ext24(s.count);
            wwd_pkg::OFF_STATUS: read_mux = {28'h0, s.status};
            wwd_pkg::OFF_IRQ_EN: read_mux = {28'h0, s.irq_en};
            default: read_mux = 32'h0;
        endcase
    endfunction

    always_comb begin
        next_st = st;
        next_st.chip_rst = 1'b0;
        // two-flop sync of the rc clock, third stage for edge
        next_st.rc_sync = {st.rc_sync[1:0], i_internal_rc_oscillator};
        rc_rise = st.rc_sync[1] & ~st.rc_sync[2];
        step = st.en && rc_rise && (st.presc == wwd_pkg::PRESC_LAST);
        feed_ok = 1'b0;
        ev_warn = 1'b0;
        ev_feed_fault = 1'b0;
        ev_win_fault = 1'b0;
        ev_timeout = 1'b0;
        st_clr = 4'h0;

        if (i_req.we) begin
            case (i_req.addr)
                wwd_pkg::OFF_CTRL: begin
                    next_st.en = st.en | i_req.wdata[wwd_pkg::CTRL_EN];
                    next_st.fault_irq = i_req.wdata[wwd_pkg::CTRL_FAULT_IRQ];
                    next_st.win_en = i_req.wdata[wwd_pkg::CTRL_WIN_EN];
                    if (i_req.wdata[wwd_pkg::CTRL_EN] && !st.en) begin
                        next_st.count = st.timeout;
                        next_st.presc = 2'h0;
                    end
                end
                wwd_pkg::OFF_TIMEOUT: begin
                    next_st.timeout = clamp_timeout(i_req.wdata[wwd_pkg::CNT_W-1:0]);
                end
                wwd_pkg::OFF_WARN: begin
                    next_st.warn = i_req.wdata[wwd_pkg::CNT_W-1:0];
                end
                wwd_pkg::OFF_WINDOW: begin
                    next_st.window = i_req.wdata[wwd_pkg::CNT_W-1:0];
                end
                wwd_pkg::OFF_CLEAR: begin
                    st_clr = i_req.wdata[wwd_pkg::ST_W-1:0];
                end
                wwd_pkg::OFF_IRQ_EN: begin
                    next_st.irq_en = i_req.wdata[wwd_pkg::ST_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // feed key pair must be two back-to-back accesses
        if (st.feed_armed && (i_req.we || i_req.re)) begin
            next_st.feed_armed = 1'b0;
            if (i_req.we && i_req.addr == wwd_pkg::OFF_FEED
                    && i_req.wdata[7:0] == wwd_pkg::FEED_KEY2) begin
                feed_ok = 1'b1;
            end else begin
                ev_feed_fault = st.en;
            end
        end else if (i_req.we && i_req.addr == wwd_pkg::OFF_FEED) begin
            if (i_req.wdata[7:0] == wwd_pkg::FEED_KEY1) begin
                next_st.feed_armed = 1'b1;
            end else begin
                ev_feed_fault = st.en;
            end
        end

        if (feed_ok && st.en) begin
            if (st.win_en && st.count > st.window) begin
                ev_win_fault = 1'b1;
            end else begin
                next_st.count = st.timeout;
                next_st.presc = 2'h0;
            end
        end else if (st.en && rc_rise) begin
            next_st.presc = st.presc + 2'h1;
            if (step) begin
                if (st.count == 24'h000000) begin
                    ev_timeout = 1'b1;
                end else begin
                    next_st.count = st.count - 24'h000001;
                    ev_warn = (st.count - 24'h000001) == st.warn;
                end
            end
        end

        fault = ev_feed_fault | ev_win_fault;
        if (ev_timeout || (fault && !st.fault_irq)) begin
            next_st.chip_rst = 1'b1;
            next_st.en = 1'b0;
        end
        if (fault && st.fault_irq) begin
            next_st.en = 1'b0;
        end

        st_set = 4'h0;
        st_set[wwd_pkg::ST_WARN] = ev_warn;
        st_set[wwd_pkg::ST_FEED_FAULT] = ev_feed_fault && st.fault_irq;
        st_set[wwd_pkg::ST_WIN_FAULT] = ev_win_fault && st.fault_irq;
        st_set[wwd_pkg::ST_WD_RESET] = next_st.chip_rst;
        next_st.status = (st.status & ~st_clr) | st_set;

        next_st.rdata = i_req.re ? read_mux(st, i_req.addr) : 32'h0;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_por_rst) begin
            st <= ST_RST;
        end else if (i_srst) begin
            st <= ST_RST;
            st.status[wwd_pkg::ST_WD_RESET] <= st.status[wwd_pkg::ST_WD_RESET];
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_chip_rst = st.chip_rst;
    assign o_irq = |(st.status & st.irq_en);

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst || i_por_rst);

    sequence key1_write_s;
        st.en && !st.feed_armed && i_req.we && i_req.addr == wwd_pkg::OFF_FEED
            && i_req.wdata[7:0] == wwd_pkg::FEED_KEY1;
    endsequence

    sequence wrong_follow_s;
        (i_req.we || i_req.re) && !(i_req.we && i_req.addr == wwd_pkg::OFF_FEED
            && i_req.wdata[7:0] == wwd_pkg::FEED_KEY2);
    endsequence

    sequence good_feed_s;
        st.en && feed_ok && !(st.win_en && st.count > st.window);
    endsequence

    // further steps of enabling, feeding, clearing, reading and timeout writes
    sequence enable_write_s;
        i_req.we && i_req.addr == wwd_pkg::OFF_CTRL && i_req.wdata[wwd_pkg::CTRL_EN] && !st.en;
    endsequence

    sequence early_feed_s;
        st.en && feed_ok && st.win_en && st.count > st.window;
    endsequence

    sequence clear_warn_s;
        i_req.we && i_req.addr == wwd_pkg::OFF_CLEAR && i_req.wdata[wwd_pkg::ST_WARN];
    endsequence

    sequence count_read_s;
        i_req.re && i_req.addr == wwd_pkg::OFF_COUNT;
    endsequence

    sequence timeout_write_s;
        i_req.we && i_req.addr == wwd_pkg::OFF_TIMEOUT
            && i_req.wdata[wwd_pkg::CNT_W-1:0] >= wwd_pkg::TIMEOUT_MIN;
    endsequence

    timeout_reset_a: assert property (
        (step && st.count == 24'h000000 && !feed_ok) |=> o_chip_rst && !st.en)
        else $error("timeout did not reset chip");

    window_early_a: assert property (
        (st.en && feed_ok && st.win_en && st.count > st.window && !st.fault_irq)
            |=> o_chip_rst)
        else $error("early feed in window mode not faulted");

    warn_flag_a: assert property (
        (step && !feed_ok && st.count != 24'h000000
            && st.count == st.warn + 24'h000001) |=> st.status[wwd_pkg::ST_WARN])
        else $error("warning status not set");

    enable_hold_a: assert property (
        (st.en && !ev_timeout && !fault) |=> st.en)
        else $error("enable dropped without event");

    feed_seq_a: assert property (
        ((st.feed_armed && st.en && !st.fault_irq) ##0 wrong_follow_s) |=> o_chip_rst)
        else $error("bad feed sequence not reset");

    reset_flag_a: assert property (
        o_chip_rst |-> st.status[wwd_pkg::ST_WD_RESET])
        else $error("watchdog reset flag missing");

    prescale_hold_a: assert property (
        (st.en && !feed_ok && !step && !(i_req.we && i_req.addr == wwd_pkg::OFF_CTRL))
            |=> $stable(st.count))
        else $error("count moved between prescaler wraps");

    timeout_min_a: assert property (
        st.timeout >= wwd_pkg::TIMEOUT_MIN)
        else $error("timeout below minimum");

    reload_a: assert property (
        good_feed_s |=> (st.count == $past(st.timeout) && st.presc == 2'h0))
        else $error("valid feed did not reload");

    // feed key tracking
    arm_key_a: assert property (
        key1_write_s |=> st.feed_armed)
        else $error("first key did not arm feed");

    feed_disarm_a: assert property (
        (st.feed_armed && (i_req.we || i_req.re)) |=> !st.feed_armed)
        else $error("feed stayed armed after access");

    // reset request behaviour
    chip_pulse_a: assert property (
        o_chip_rst |=> !o_chip_rst)
        else $error("chip reset longer than one cycle");

    rst_disable_a: assert property (
        o_chip_rst |-> !st.en)
        else $error("enable kept after chip reset");

    enable_load_a: assert property (
        enable_write_s |=> (st.en && st.count == $past(st.timeout) && st.presc == 2'h0))
        else $error("enable did not load count");

    fault_irq_a: assert property (
        ((st.feed_armed && st.en && st.fault_irq) ##0 wrong_follow_s)
            |=> (st.status[wwd_pkg::ST_FEED_FAULT] && !st.en))
        else $error("bad feed sequence not flagged");

    // window checks
    win_irq_a: assert property (
        (early_feed_s ##0 st.fault_irq) |=> (st.status[wwd_pkg::ST_WIN_FAULT] && !st.en))
        else $error("early feed not flagged");

    win_ok_a: assert property (
        good_feed_s |=> (st.en && !o_chip_rst))
        else $error("valid feed caused fault");

    // counting
    idle_count_a: assert property (
        (!st.en && !(i_req.we && i_req.addr == wwd_pkg::OFF_CTRL))
            |=> ($stable(st.count) && $stable(st.presc)))
        else $error("disabled watchdog counted");

    presc_step_a: assert property (
        (st.en && rc_rise && !feed_ok && !(i_req.we && i_req.addr == wwd_pkg::OFF_CTRL))
            |=> st.presc == $past(st.presc) + 2'h1)
        else $error("prescaler missed a tick");

    warn_clear_a: assert property (
        (clear_warn_s ##0 !ev_warn) |=> !st.status[wwd_pkg::ST_WARN])
        else $error("warning status not cleared");

    // register reads and writes
    count_read_a: assert property (
        count_read_s |=> o_rdata == ext24($past(st.count)))
        else $error("count read wrong");

    ctrl_read_a: assert property (
        (i_req.re && i_req.addr == wwd_pkg::OFF_CTRL)
            |=> o_rdata[wwd_pkg::CTRL_EN] == $past(st.en))
        else $error("enable read wrong");

    timeout_load_a: assert property (
        timeout_write_s |=> st.timeout == $past(i_req.wdata[wwd_pkg::CNT_W-1:0]))
        else $error("timeout write lost");
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module tb_top;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_por_rst = 1'b1;
    logic i_internal_rc_oscillator = 1'b0;
    wwd_pkg::wwd_req_s i_req = '0;
    logic [31:0] o_rdata;
    logic o_irq;
    logic o_chip_rst;
    int miscompares = 0;
    int total_checks = 0;
    int seed = 32'h0632;
    logic [2:0] rc_div = 3'h0;
    logic [31:0] d;
    logic [23:0] v;

    wwd_windowed_watchdog i_dut (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_por_rst(i_por_rst),
        .i_internal_rc_oscillator(i_internal_rc_oscillator),
        .i_req(i_req),
        .o_rdata(o_rdata),
        .o_irq(o_irq),
        .o_chip_rst(o_chip_rst)
    );

    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end

    // rc clock at one eighth of the system rate
    always @(posedge i_sys_clk) begin
        rc_div <= rc_div + 3'h1;
        if (rc_div[1:0] == 2'h3) begin
            i_internal_rc_oscillator <= ~i_internal_rc_oscillator;
        end
    end

    function automatic logic [23:0] exp_timeout(input logic [23:0] x);
        return (x < 24'h000100) ? 24'h000100 : x;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_sys_clk);
        i_req <= '{addr: a, wdata: wd, we: 1'b1, re: 1'b0};
        @(posedge i_sys_clk);
        i_req.we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
        @(posedge i_sys_clk);
        i_req.re <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic feed();
        wr(wwd_pkg::OFF_FEED, 32'h000000aa);
        wr(wwd_pkg::OFF_FEED, 32'h00000055);
    endtask

    task automatic wait_sig(input int n, input bit irq);
        for (int i = 0; i < n; i++) begin
            #1;
            if ((irq ? o_irq : o_chip_rst) === 1'b1) break;
            @(posedge i_sys_clk);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #(100 * 40000);
        miscompares++;
        complete_run();
    end

    initial begin
        repeat (12) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        i_por_rst <= 1'b0;
        rd(wwd_pkg::OFF_TIMEOUT);
        `CHK("timeout", 32'h00ffffff, d)
        rd(wwd_pkg::OFF_WINDOW);
        `CHK("window", 32'h00ffffff, d)
        rd(8'h40);
        `CHK("unmapped", 32'h0, d)
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 24'h0000ff : (k == 1) ? 24'h000100 : 24'($random(seed));
            wr(wwd_pkg::OFF_TIMEOUT, {8'h0, v});
            rd(wwd_pkg::OFF_TIMEOUT);
            `CHK("timeout wr", {8'h0, exp_timeout(v)}, d)
        end
        wr(wwd_pkg::OFF_TIMEOUT, 32'h00000100);
        wr(wwd_pkg::OFF_WARN, 32'h00000080);
        wr(wwd_pkg::OFF_IRQ_EN, 32'h00000001);
        wr(wwd_pkg::OFF_CTRL, 32'h00000001);
        wait_sig(6000, 1'b1);
        `CHK("warn irq", 1'b1, o_irq)
        rd(wwd_pkg::OFF_COUNT);
        `CHK("warn count", 32'h00000080, d)
        feed();
        rd(wwd_pkg::OFF_COUNT);
        `CHK("reload", 32'h00000100, d)
        wr(wwd_pkg::OFF_CLEAR, 32'h00000001);
        #1 `CHK("irq clr", 1'b0, o_irq)
        wr(wwd_pkg::OFF_CTRL, 32'h00000000);
        rd(wwd_pkg::OFF_CTRL);
        `CHK("en lock", 1'b1, d[0])
        wait_sig(10000, 1'b0);
        `CHK("expire rst", 1'b1, o_chip_rst)
        @(posedge i_sys_clk);
        #1 `CHK("rst pulse", 1'b0, o_chip_rst)
        rd(wwd_pkg::OFF_CTRL);
        `CHK("en clr", 1'b0, d[0])
        i_srst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        rd(wwd_pkg::OFF_STATUS);
        `CHK("wd flag", 1'b1, d[3])
        wr(wwd_pkg::OFF_CLEAR, 32'h0000000f);
        wr(wwd_pkg::OFF_TIMEOUT, 32'h00000100);
        wr(wwd_pkg::OFF_CTRL, 32'h00000001);
        wr(wwd_pkg::OFF_FEED, 32'h000000aa);
        wr(wwd_pkg::OFF_FEED, 32'h00000012);
        wait_sig(4, 1'b0);
        `CHK("badkey rst", 1'b1, o_chip_rst)
        wr(wwd_pkg::OFF_CLEAR, 32'h0000000f);
        wr(wwd_pkg::OFF_IRQ_EN, 32'h00000006);
        wr(wwd_pkg::OFF_CTRL, 32'h00000003);
        wr(wwd_pkg::OFF_FEED, 32'h000000aa);
        rd(wwd_pkg::OFF_COUNT);
        wait_sig(4, 1'b1);
        rd(wwd_pkg::OFF_STATUS);
        `CHK("seq fault", 4'h2, d[3:0])
        `CHK("seq irq", 1'b1, o_irq)
        wr(wwd_pkg::OFF_CLEAR, 32'h0000000f);
        wr(wwd_pkg::OFF_WINDOW, 32'h00000010);
        wr(wwd_pkg::OFF_CTRL, 32'h00000007);
        feed();
        wait_sig(4, 1'b1);
        rd(wwd_pkg::OFF_STATUS);
        `CHK("early feed", 4'h4, d[3:0])
        wr(wwd_pkg::OFF_CLEAR, 32'h0000000f);
        wr(wwd_pkg::OFF_WINDOW, 32'h000000f8);
        wr(wwd_pkg::OFF_CTRL, 32'h00000007);
        repeat (400) @(posedge i_sys_clk);
        feed();
        rd(wwd_pkg::OFF_COUNT);
        `CHK("win feed", 32'h00000100, d)
        rd(wwd_pkg::OFF_STATUS);
        `CHK("win ok", 4'h0, d[3:0])
        complete_run();
    end
endmodule
